/* File: design/bit_index_decode.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Point index to main or extended bit position
module bit_index_decode (
  input wire logic [6:0] index,
  output logic is_main,
  output logic is_ext,
  output logic [5:0] ext_pos,
  output logic [2:0] main_pos
);
  wire [6:0] ext_off = index - 7'(ext_io_pkg::FIRST_EXT_INDEX);
  wire [6:0] main_off = index - 7'(ext_io_pkg::FIRST_MAIN_INDEX);
  // Range checks; anything else is ignored
  assign is_main = (index >= 7'(ext_io_pkg::FIRST_MAIN_INDEX)) && (index <= 7'(ext_io_pkg::LAST_MAIN_INDEX));
  assign is_ext = (index >= 7'(ext_io_pkg::FIRST_EXT_INDEX)) && (index <= 7'(ext_io_pkg::LAST_EXT_INDEX));
  assign ext_pos = ext_off[5:0];
  assign main_pos = main_off[2:0];
endmodule : bit_index_decode
`default_nettype wire

/* File: design/ext_io_pkg.sv */
package ext_io_pkg;
  // ==========================================================================
  // Geometry
  localparam int unsigned NUM_EXT_BLOCKS = 8;
  localparam int unsigned BLOCK_BITS = 8;
  localparam int unsigned EXT_BITS = 64;
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned NUM_WORDS = 4;
  localparam int unsigned FIRST_EXT_INDEX = 17;
  localparam int unsigned LAST_EXT_INDEX = 80;
  localparam int unsigned FIRST_MAIN_INDEX = 1;
  localparam int unsigned LAST_MAIN_INDEX = 8;
  localparam int unsigned FIRST_EXT_BLOCK = 2;
  localparam int unsigned LAST_EXT_BLOCK = 9;
  localparam int unsigned MAIN_BLOCK = 0;
  // ==========================================================================
  // Reset values
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] MAIN_OUT_RESET = 8'h00;
  localparam logic [63:0] EXT_OUT_RESET = 64'h0000_0000_0000_0000;
  // ==========================================================================
  // Block 2 is output only on high axis count builds
  localparam int unsigned OUT_ONLY_BLOCK_POS = 0;
  // ==========================================================================
  // Command encoding
  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_SET_BIT,
    CMD_CLEAR_BIT,
    CMD_COND_BIT,
    CMD_CONFIG,
    CMD_PORT_WRITE,
    CMD_SAVE
  } cmd_t;
endpackage : ext_io_pkg

/* File: design/ext_io_port.sv */
`timescale 1ns/1ns
`default_nettype none
// Function
// - 64 extended points, direction chosen per group of eight
// - Blocks 2..9 hold indices 17..80, ascending eight per block
// - Direction mask bit at 1 makes its block drive outputs
// - Direction mask bit at 0 makes its block inputs
// - Mask bit 0 is block 2, bit 7 is block 9
// - Without stored configuration the mask is zero, all inputs
// - Save request writes mask and output states to non-volatile store
// - Set and clear single output bit, index 1..8 or 17..80
// - Conditional write drives an output bit to the supplied level
// - Port write first argument sets the eight main outputs
// - Four 16-bit arguments set bits 17..80 in order, LSB first
// - Port write parts for input blocks are discarded
// - Given arguments overwrite their group; omitted groups keep state
// - Block read returns block 0 or 2..9 as eight bits
// - Single point query, index 17 is LSB of block 2
// - On high axis builds block 2 is output only
module ext_io_port #(
  parameter bit BLOCK2_OUT_ONLY = 1'b0
) (
  input wire logic clk_sys,
  input wire logic nrst,
  // Command port
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_op,
  input wire logic [6:0] cmd_index,
  input wire logic cmd_level,
  input wire logic [7:0] block_direction_config,
  input wire logic [7:0] port_main_arg,
  input wire logic [63:0] port_ext_arg,
  input wire logic [4:0] port_arg_given,
  // Block read and point query
  input wire logic [3:0] block_read_cmd,
  output logic [7:0] block_read_data,
  output logic block_read_ok,
  input wire logic [6:0] query_index,
  output logic query_data,
  output logic query_ok,
  // Non-volatile store
  input wire logic nvm_valid,
  input wire logic [7:0] nvm_dir,
  input wire logic [7:0] nvm_main,
  input wire logic [63:0] nvm_ext,
  output logic save_to_nvm,
  output logic [7:0] save_dir,
  output logic [7:0] save_main,
  output logic [63:0] save_ext,
  // Pins
  output logic [7:0] main_out,
  input wire logic [7:0] main_in_pin,
  input wire logic [63:0] ext_in_pin,
  output logic [63:0] ext_out,
  output logic [63:0] ext_oe_n,
  output logic [7:0] dir_status
);
  // ==========================================================================
  // State
  typedef enum logic [1:0] {ST_LOAD, ST_RUN} init_t;
  init_t init_r;
  logic [7:0] dir_r;
  logic [7:0] dir_nxt;
  logic [7:0] main_r;
  logic [7:0] main_nxt;
  logic [63:0] ext_r;
  logic [63:0] ext_nxt;
  logic save_r;
  logic [7:0] save_dir_r;
  logic [7:0] save_main_r;
  logic [63:0] save_ext_r;
  logic [7:0] rd_r;
  logic rd_ok_r;
  logic q_r;
  logic q_ok_r;

  // ==========================================================================
  // Input synchronisers
  logic [63:0] ext_in_s;
  logic [7:0] main_in_s;
  sync3 #(.WIDTH(64)) u_sync_ext (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .pin_in(ext_in_pin),
    .level_out(ext_in_s)
  );
  sync3 #(.WIDTH(8)) u_sync_main (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .pin_in(main_in_pin),
    .level_out(main_in_s)
  );

  // ==========================================================================
  // Index decode for bit commands and queries
  logic c_main;
  logic c_ext;
  logic [5:0] c_epos;
  logic [2:0] c_mpos;
  logic q_main;
  logic q_ext;
  logic [5:0] q_epos;
  logic [2:0] q_mpos;
  bit_index_decode u_dec_cmd (
    .index(cmd_index),
    .is_main(c_main),
    .is_ext(c_ext),
    .ext_pos(c_epos),
    .main_pos(c_mpos)
  );
  bit_index_decode u_dec_query (
    .index(query_index),
    .is_main(q_main),
    .is_ext(q_ext),
    .ext_pos(q_epos),
    .main_pos(q_mpos)
  );

  // ==========================================================================
  // Per point direction, block 2 may be forced to output
  wire [7:0] dir_eff = dir_r | (BLOCK2_OUT_ONLY ? 8'h01 : 8'h00);
  logic [63:0] out_mask;
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      out_mask[b*8 +: 8] = {8{dir_eff[b]}};
    end
  end

  // Bit command decode
  wire is_bit_cmd = cmd_valid && (init_r == ST_RUN) &&
                    (cmd_op == 3'(ext_io_pkg::CMD_SET_BIT) || cmd_op == 3'(ext_io_pkg::CMD_CLEAR_BIT) ||
                     cmd_op == 3'(ext_io_pkg::CMD_COND_BIT));
  wire bit_level = (cmd_op == 3'(ext_io_pkg::CMD_SET_BIT)) ? 1'b1 :
                   (cmd_op == 3'(ext_io_pkg::CMD_CLEAR_BIT)) ? 1'b0 : cmd_level;
  wire bit_ext_ok = is_bit_cmd && c_ext && out_mask[c_epos];
  wire bit_main_ok = is_bit_cmd && c_main;
  wire is_port = cmd_valid && (init_r == ST_RUN) && (cmd_op == 3'(ext_io_pkg::CMD_PORT_WRITE));
  wire is_cfg = cmd_valid && (init_r == ST_RUN) && (cmd_op == 3'(ext_io_pkg::CMD_CONFIG));
  wire is_save = cmd_valid && (init_r == ST_RUN) && (cmd_op == 3'(ext_io_pkg::CMD_SAVE));

  // Port write: given word over output points only, everything else kept
  logic [63:0] port_sel;
  always_comb begin
    for (int w = 0; w < 4; w++) begin
      port_sel[w*16 +: 16] = {16{port_arg_given[w+1]}};
    end
  end
  wire [63:0] port_wmask = port_sel & out_mask;
  wire [63:0] ext_port = (ext_r & ~port_wmask) | (port_ext_arg & port_wmask);

  // Next state selection
  always_comb begin
    dir_nxt = dir_r;
    main_nxt = main_r;
    ext_nxt = ext_r;
    if (init_r == ST_LOAD) begin
      dir_nxt = nvm_valid ? nvm_dir : ext_io_pkg::DIR_RESET;
      main_nxt = nvm_valid ? nvm_main : ext_io_pkg::MAIN_OUT_RESET;
      ext_nxt = nvm_valid ? nvm_ext : ext_io_pkg::EXT_OUT_RESET;
    end else if (is_cfg) begin
      dir_nxt = block_direction_config;
    end else if (is_port) begin
      if (port_arg_given[0]) begin
        main_nxt = port_main_arg;
      end
      ext_nxt = ext_port;
    end else if (bit_ext_ok) begin
      ext_nxt[c_epos] = bit_level;
    end else if (bit_main_ok) begin
      main_nxt[c_mpos] = bit_level;
    end
  end

  // Outputs and direction registers; ST_LOAD holds blocks 3..9 as input, and block 2 also unless BLOCK2_OUT_ONLY
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      init_r <= ST_LOAD;
      dir_r <= ext_io_pkg::DIR_RESET;
      main_r <= ext_io_pkg::MAIN_OUT_RESET;
      ext_r <= ext_io_pkg::EXT_OUT_RESET;
    end else begin
      init_r <= ST_RUN;
      dir_r <= dir_nxt;
      main_r <= main_nxt;
      ext_r <= ext_nxt;
    end
  end

  // Snapshot for the non-volatile store, one cycle strobe
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      save_r <= 1'b0;
      save_dir_r <= 8'h00;
      save_main_r <= 8'h00;
      save_ext_r <= 64'h0000_0000_0000_0000;
    end else begin
      save_r <= is_save;
      if (is_save) begin
        save_dir_r <= dir_r;
        save_main_r <= main_r;
        save_ext_r <= ext_r;
      end
    end
  end

  // ==========================================================================
  // Readback: extended output points show driven state, extended input points and main block 0 the pin
  wire [63:0] ext_view = (ext_r & out_mask) | (ext_in_s & ~out_mask);
  wire [3:0] blk_off = block_read_cmd - 4'(ext_io_pkg::FIRST_EXT_BLOCK);
  wire blk_main = (block_read_cmd == 4'(ext_io_pkg::MAIN_BLOCK));
  wire blk_ext = (block_read_cmd >= 4'(ext_io_pkg::FIRST_EXT_BLOCK)) &&
                 (block_read_cmd <= 4'(ext_io_pkg::LAST_EXT_BLOCK));
  wire [7:0] blk_val = blk_main ? main_in_s : (blk_ext ? ext_view[blk_off[2:0]*8 +: 8] : 8'h00);

  // Registered answers, one cycle after the request
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rd_r <= 8'h00;
      rd_ok_r <= 1'b0;
      q_r <= 1'b0;
      q_ok_r <= 1'b0;
    end else begin
      rd_r <= blk_val;
      rd_ok_r <= blk_main | blk_ext;
      q_r <= q_ext ? ext_view[q_epos] : (q_main ? main_in_s[q_mpos] : 1'b0);
      q_ok_r <= q_ext | q_main;
    end
  end

  // ==========================================================================
  // Port drive; enable low while driving
  assign ext_out = ext_r;
  assign ext_oe_n = ~out_mask;
  assign main_out = main_r;
  assign dir_status = dir_r;
  assign block_read_data = rd_r;
  assign block_read_ok = rd_ok_r;
  assign query_data = q_r;
  assign query_ok = q_ok_r;
  assign save_to_nvm = save_r;
  assign save_dir = save_dir_r;
  assign save_main = save_main_r;
  assign save_ext = save_ext_r;

  // ==========================================================================
  // Checks
  property p_dir_drive;
    @(posedge clk_sys) disable iff (!nrst)
      ext_oe_n[8] == !dir_eff[1];
  endproperty
  a_dir_drive: assert property (p_dir_drive) else $error("block 3 enable mismatch");

  property p_dir_input;
    @(posedge clk_sys) disable iff (!nrst)
      !dir_eff[7] |-> ext_oe_n[63:56] == 8'hff;
  endproperty
  a_dir_input: assert property (p_dir_input) else $error("input block driven");

  property p_reset_inputs;
    @(posedge clk_sys) $rose(nrst) |-> ext_oe_n[63:8] == 56'hff_ffff_ffff_ffff;
  endproperty
  a_reset_inputs: assert property (p_reset_inputs) else $error("block driven during load");

  property p_default_dir;
    @(posedge clk_sys) disable iff (!nrst)
      init_r == ST_LOAD && !nvm_valid |=> dir_status == 8'h00;
  endproperty
  a_default_dir: assert property (p_default_dir) else $error("default mask not zero");

  property p_set_bit;
    @(posedge clk_sys) disable iff (!nrst)
      is_bit_cmd && cmd_op == 3'(ext_io_pkg::CMD_SET_BIT) && bit_ext_ok |=> ext_out[$past(c_epos)];
  endproperty
  a_set_bit: assert property (p_set_bit) else $error("set bit lost");

  property p_cond_bit;
    @(posedge clk_sys) disable iff (!nrst)
      bit_main_ok && cmd_op == 3'(ext_io_pkg::CMD_COND_BIT) |=> main_out[$past(c_mpos)] == $past(cmd_level);
  endproperty
  a_cond_bit: assert property (p_cond_bit) else $error("conditional bit wrong");

  property p_port_ignore;
    @(posedge clk_sys) disable iff (!nrst)
      is_port && !out_mask[16] |=> $stable(ext_out[23:16]);
  endproperty
  a_port_ignore: assert property (p_port_ignore) else $error("input block written");

  property p_port_main;
    @(posedge clk_sys) disable iff (!nrst)
      is_port && port_arg_given[0] |=> main_out == $past(port_main_arg);
  endproperty
  a_port_main: assert property (p_port_main) else $error("main outputs not written");

  // Snapshot taken from the state seen at the request edge
  sequence s_save_pulse;
    save_to_nvm && save_dir == $past(dir_status) && save_main == $past(main_out) && save_ext == $past(ext_out);
  endsequence
  // Strobe drops next cycle unless a second save came back to back
  sequence s_save_end;
    !save_to_nvm || $past(is_save);
  endsequence
  property p_save;
    @(posedge clk_sys) disable iff (!nrst)
      is_save |=> s_save_pulse ##1 s_save_end;
  endproperty
  a_save: assert property (p_save) else $error("save strobe wrong");

  property p_block2_out;
    @(posedge clk_sys) disable iff (!nrst)
      BLOCK2_OUT_ONLY |-> ext_oe_n[7:0] == 8'h00;
  endproperty
  a_block2_out: assert property (p_block2_out) else $error("block 2 not driving");
endmodule : ext_io_port
`default_nettype wire

/* File: design/sync3.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Three stage pin synchroniser; accepts a change once stages two and three agree
module sync3 #(
  parameter int unsigned WIDTH = 64
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] level_r;
  // Stage one feeds only stage two
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      level_r <= '0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_r <= (s2_r & s3_r) | (level_r & (s2_r | s3_r));
    end
  end
  assign level_out = level_r;
endmodule : sync3
`default_nettype wire

/* File: tb/extended_io_block_config_test.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module extended_io_block_config_test;
  logic clk_sys, nrst, cmd_valid, cmd_level, nvm_valid, query_data, query_ok, block_read_ok, save_to_nvm;
  logic [2:0] cmd_op;
  logic [3:0] block_read_cmd;
  logic [4:0] port_arg_given;
  logic [6:0] cmd_index, query_index;
  logic [7:0] block_direction_config, port_main_arg, nvm_dir, nvm_main, main_in_pin, block_read_data;
  logic [7:0] save_dir, save_main, main_out, dir_status, m_dir, m_main;
  logic [63:0] port_ext_arg, nvm_ext, ext_in_pin, save_ext, ext_out, ext_oe_n, rack_in, m_ext;
  logic [31:0] seed = 32'h0000_0035;
  logic [31:0] r;
  ext_io_pkg::cmd_t op;
  int fails, tests_run, idx, kb;
  int corner[8] = '{1, 8, 17, 24, 80, 0, 9, 81};
  // ==========================================================================
  // Design and far side
  ext_io_port #(.BLOCK2_OUT_ONLY(1'b0)) i_ext_io_port (.clk_sys, .nrst, .cmd_valid, .cmd_op, .cmd_index,
    .cmd_level, .block_direction_config, .port_main_arg, .port_ext_arg, .port_arg_given, .block_read_cmd,
    .block_read_data, .block_read_ok, .query_index, .query_data, .query_ok, .nvm_valid, .nvm_dir, .nvm_main,
    .nvm_ext, .save_to_nvm, .save_dir, .save_main, .save_ext, .main_out, .main_in_pin, .ext_in_pin, .ext_out,
    .ext_oe_n, .dir_status);
  io_rack i_io_rack (.ext_out, .ext_oe_n, .rack_in, .ext_in_pin);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // ==========================================================================
  // Expectation helpers
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function logic [63:0] oe_of(input logic [7:0] d);
    for (int i = 0; i < 64; i++) oe_of[i] = ~d[i / 8];
  endfunction : oe_of
  // Output points read back their drive, input points the rack level
  function logic pt(input int p);
    return m_dir[p / 8] ? m_ext[p] : rack_in[p];
  endfunction : pt
  function logic [7:0] blk_exp(input int b);
    if (b == 0) return main_in_pin;
    for (int j = 0; j < 8; j++) blk_exp[j] = pt((b - 2) * 8 + j);
  endfunction : blk_exp
  task put(input int i, input logic v);
    if (i >= 1 && i <= 8) m_main[i - 1] = v;
    else if (i >= 17 && i <= 80 && m_dir[(i - 17) / 8]) m_ext[i - 17] = v;
  endtask : put
  task check_state();
    `CHK(main_out, m_main);
    `CHK(ext_out, m_ext);
    `CHK(dir_status, m_dir);
    `CHK(ext_oe_n, oe_of(m_dir));
  endtask : check_state
  // Valid stays up between calls, so consecutive calls are back to back
  task issue(input ext_io_pkg::cmd_t c, input int i, input logic lvl);
    cmd_op = c;
    cmd_index = i[6:0];
    cmd_level = lvl;
    cmd_valid = 1'b1;
    @(negedge clk_sys);
    case (c)
      ext_io_pkg::CMD_SET_BIT: put(i, 1'b1);
      ext_io_pkg::CMD_CLEAR_BIT: put(i, 1'b0);
      ext_io_pkg::CMD_COND_BIT: put(i, lvl);
      ext_io_pkg::CMD_CONFIG: m_dir = block_direction_config;
      ext_io_pkg::CMD_PORT_WRITE: begin
        if (port_arg_given[0]) m_main = port_main_arg;
        for (int p = 0; p < 64; p++) if (port_arg_given[1 + p / 16] && m_dir[p / 8]) m_ext[p] = port_ext_arg[p];
      end
      ext_io_pkg::CMD_SAVE: begin
        `CHK(save_to_nvm, 1'b1);
        `CHK({save_dir, save_main, save_ext}, {m_dir, m_main, m_ext});
      end
      default: ;
    endcase
    check_state();
  endtask : issue
  task idle();
    cmd_valid = 1'b0;
    @(negedge clk_sys);
  endtask : idle
  task do_reset(input logic v);
    nrst = 1'b0;
    cmd_valid = 1'b0;
    nvm_valid = v;
    nvm_dir = 8'(rnd());
    nvm_main = 8'(rnd());
    nvm_ext = {rnd(), rnd()};
    repeat (3) @(negedge clk_sys);
    `CHK({main_out, ext_out, dir_status, save_to_nvm}, 81'h0);
    `CHK(ext_oe_n, {64{1'b1}});
    nrst = 1'b1;
    // A command at the load edge must be dropped
    cmd_op = ext_io_pkg::CMD_CONFIG;
    block_direction_config = 8'hff;
    cmd_valid = 1'b1;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    repeat (2) @(negedge clk_sys);
    m_dir = v ? nvm_dir : 8'h00;
    m_main = v ? nvm_main : 8'h00;
    m_ext = v ? nvm_ext : 64'h0000_0000_0000_0000;
    check_state();
  endtask : do_reset
  task end_sim();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  // ==========================================================================
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    $display("run limit reached");
    end_sim();
  end
  // ==========================================================================
  // Main sequence
  initial begin
    {cmd_op, cmd_index, cmd_level, block_direction_config, port_main_arg, port_ext_arg, port_arg_given} = '0;
    {block_read_cmd, query_index, main_in_pin, rack_in} = '0;
    do_reset(1'b0);
    $display("test reset done");
    // Each mask bit alone, then blocks 4 and 5, then random masks
    for (int i = 0; i < 12; i++) begin
      block_direction_config = (i < 8) ? 8'h01 << i : (i == 8 ? 8'h0c : 8'(rnd()));
      issue(ext_io_pkg::CMD_CONFIG, 0, 1'b0);
    end
    $display("test config done");
    // Back-to-back bit commands; out-of-range indices must be ignored
    for (int i = 0; i < 60; i++) begin
      r = rnd();
      idx = (i < 8) ? corner[i] : int'(r[6:0]);
      if (r[9]) op = ext_io_pkg::CMD_COND_BIT;
      else if (r[8]) op = ext_io_pkg::CMD_SET_BIT;
      else op = ext_io_pkg::CMD_CLEAR_BIT;
      issue(op, idx, r[10]);
    end
    // Empty and unknown opcodes change nothing
    issue(ext_io_pkg::CMD_NONE, 17, 1'b1);
    cmd_op = 3'h7;
    @(negedge clk_sys);
    check_state();
    idle();
    $display("test bit commands done");
    // Block 8 only: main gets 7, arg d gets 7, other groups untouched
    block_direction_config = 8'h40;
    port_main_arg = 8'h07;
    port_ext_arg = {16'h0007, 48'hffff_ffff_ffff};
    port_arg_given = 5'b1_0001;
    issue(ext_io_pkg::CMD_CONFIG, 0, 1'b0);
    issue(ext_io_pkg::CMD_PORT_WRITE, 0, 1'b0);
    for (int i = 0; i < 16; i++) begin
      block_direction_config = 8'(rnd());
      port_main_arg = 8'(rnd());
      port_ext_arg = {rnd(), rnd()};
      port_arg_given = 5'(rnd());
      issue(ext_io_pkg::CMD_CONFIG, 0, 1'b0);
      issue(ext_io_pkg::CMD_PORT_WRITE, 0, 1'b0);
    end
    issue(ext_io_pkg::CMD_SAVE, 0, 1'b0);
    idle();
    `CHK(save_to_nvm, 1'b0);
    $display("test port write and save done");
    // Input levels need the synchroniser delay before reading
    rack_in = {rnd(), rnd()};
    main_in_pin = 8'(rnd());
    repeat (8) idle();
    for (int k = 0; k < 91; k++) begin
      block_read_cmd = 4'(k);
      query_index = 7'(k);
      kb = k % 16;
      @(negedge clk_sys);
      `CHK(block_read_ok, 1'(kb == 0 || (kb >= 2 && kb <= 9)));
      if (kb == 0 || (kb >= 2 && kb <= 9)) `CHK(block_read_data, blk_exp(kb));
      `CHK(query_ok, 1'((k >= 1 && k <= 8) || (k >= 17 && k <= 80)));
      if (k >= 1 && k <= 8) `CHK(query_data, main_in_pin[k - 1]);
      if (k >= 17 && k <= 80) `CHK(query_data, pt(k - 17));
    end
    $display("test reads done");
    // Second reset with a stored state present
    do_reset(1'b1);
    issue(ext_io_pkg::CMD_SET_BIT, 80, 1'b0);
    idle();
    $display("test stored reload done");
    end_sim();
  end
endmodule : extended_io_block_config_test
`undef CHK
`default_nettype wire

/* File: tb/io_rack.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Rack of isolated modules on the far side of the extended points
module io_rack (
  input wire logic [63:0] ext_out,
  input wire logic [63:0] ext_oe_n,
  input wire logic [63:0] rack_in,
  output logic [63:0] ext_in_pin
);
  // Driven points loop back; released points show the module level, never the old drive
  assign ext_in_pin = (~ext_oe_n & ext_out) | (ext_oe_n & rack_in);
endmodule : io_rack
`default_nettype wire
